// ===== common/tx_bp_regs.vh
`ifndef TX_BP_REGS_VH
`define TX_BP_REGS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_CFG         12'h004
`define OFS_STATUS      12'h008

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_FRAC_SRC   7
`define CTRL_PAYLD_CLK  5
`define CTRL_FRAC_EN    4
`define CTRL_EDGE_INV   3
`define CTRL_MUX_EN     2
`define CTRL_SPEED_HI   1
`define CTRL_SPEED_LO   0
`define CTRL_WMASK      8'hBF
`define CTRL_RESET      8'h00

// ----------------------------------------------------------------
// Configuration register and interface speed codes
// ----------------------------------------------------------------
`define CFG_SCLK_DRIVE  0
`define CFG_RESET       1'b0
`define SPEED_BASE      2'h0
`define SPEED_MUX_BIT   2'h1
`define SPEED_MUX_BYTE  2'h2

// ----------------------------------------------------------------
// Clock rates in Hz
// ----------------------------------------------------------------
`define SYS_CLK_HZ      100000000
`define E1_CLK_HZ       2048000
`define MUX_CLK_HZ      16384000
`define FAST_CLK_HZ     32000000

`endif

// ===== hw/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser; the output moves once stages two and three agree
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         i;

  // ----------------------------------------------------------------
  // Sync chain with agreement filter
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= {WIDTH{1'b0}};
      s2_q    <= {WIDTH{1'b0}};
      s3_q    <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i];
    end
  end

endmodule
`default_nettype wire

// ===== hw/rate_nco.v
`timescale 1ns/1ns
`default_nettype none

// Phase accumulator: toggles its output at an average of inc/MODULUS per clk
// period so that non-integer ratios to the system clock come out exact on
// average; the cost is up to one system clock of edge jitter.
module rate_nco #(
  parameter [31:0] MODULUS = 32'd100000000
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        run,
  input  wire [31:0] inc,
  output reg         clk_q
);

  reg  [31:0] acc_q;
  wire [32:0] sum = {1'b0, acc_q} + {1'b0, inc};

  // ----------------------------------------------------------------
  // Accumulate and toggle on wrap
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 32'h00000000;
      clk_q <= 1'b0;
    end
    else if (!run)
    begin
      acc_q <= 32'h00000000;
      clk_q <= 1'b0;
    end
    else if (sum >= {1'b0, MODULUS})
    begin
      acc_q <= sum[31:0] - MODULUS;
      clk_q <= ~clk_q;
    end
    else
      acc_q <= sum[31:0];
  end

endmodule
`default_nettype wire

// ===== hw/tx_backplane_if.v
// Implementation choices: the register addresses and the APB interface to the registers.
`include "tx_bp_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module tx_backplane_if (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        tx_serial_clock_i,
  output reg         tx_serial_clock_o,
  output reg         tx_serial_clock_oe,
  input  wire        channel_clock_pin,
  input  wire        tx_serial_data,
  input  wire        tx_mframe_sync,
  input  wire [4:0]  timeslot_id_pins_i,
  output reg  [4:0]  timeslot_id_pins_o,
  output reg  [4:0]  timeslot_id_pins_oe,
  output reg  [3:0]  line_data_q,
  output reg  [3:0]  line_strobe_q,
  output reg         sig_bit_q,
  output reg         sig_strobe_q,
  output reg         frac_bit_q,
  output reg         frac_strobe_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Per-channel bit position (0..4095 in a multiframe) from link bit count
  function [11:0] chan_pos;
    input [13:0] pos;
    input        mux;
    input [1:0]  speed;
    begin
      if (!mux)
        chan_pos = pos[11:0];
      else if (speed == `SPEED_MUX_BYTE)
        chan_pos = {pos[13:5], pos[2:0]};
      else
        chan_pos = pos[13:2];
    end
  endfunction

  // Sample edge from a level pair; data changes on the other edge
  function sample_edge;
    input now;
    input prev;
    input inv;
    begin
      sample_edge = inv ? (now & ~prev) : (~now & prev);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl_q;
  reg         cfg_drive_q;
  reg  [13:0] pos_q;
  reg         clk_prev_q;
  reg         chclk_prev_q;
  reg  [4:0]  ts_o_d;
  reg  [4:0]  ts_oe_d;
  reg  [31:0] rdata_d;
  reg         addr_ok;

  wire        frac_src    = ctrl_q[`CTRL_FRAC_SRC];
  wire        payload_clk = ctrl_q[`CTRL_PAYLD_CLK];
  wire        frac_en     = ctrl_q[`CTRL_FRAC_EN];
  wire        edge_inv    = ctrl_q[`CTRL_EDGE_INV];
  wire        mux_en      = ctrl_q[`CTRL_MUX_EN];
  wire [1:0]  speed       = ctrl_q[`CTRL_SPEED_HI:`CTRL_SPEED_LO];

  // Base rate means neither multiplexed nor a high-speed code
  wire        base_rate   = ~mux_en & (speed == `SPEED_BASE);
  wire        frac_act    = base_rate & frac_en;
  wire        inv_eff     = base_rate & edge_inv;
  wire        mux_resv    = mux_en & (speed == `SPEED_BASE);

  // ----------------------------------------------------------------
  // Pin synchronisers and clock generators
  // ----------------------------------------------------------------
  wire [5:0]  pins_s;
  wire        sclk_s      = pins_s[0];
  wire        chclk_s     = pins_s[1];
  wire        data_s      = pins_s[2];
  wire        msync_s     = pins_s[3];
  wire        sig_s       = pins_s[4];
  wire        fracd_s     = pins_s[5];
  wire        sclk_free;
  wire        fast_clk;

  // Identifier pins 0 and 1 pass the same chain as the link pins, so data
  // and clock keep their relative timing through synchronisation
  pin_sync #(
    .WIDTH    (6)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({timeslot_id_pins_i[1], timeslot_id_pins_i[0], tx_mframe_sync,
                tx_serial_data, channel_clock_pin, tx_serial_clock_i}),
    .level_q  (pins_s)
  );

  // Serial clock: 2.048 MHz, or 16.384 MHz in multiplexed mode
  rate_nco #(
    .MODULUS  (`SYS_CLK_HZ)
  ) u_sclk_nco (
    .clk      (pclk),
    .rst_n    (presetn),
    .run      (cfg_drive_q),
    .inc      (mux_en ? 2 * `MUX_CLK_HZ : 2 * `E1_CLK_HZ),
    .clk_q    (sclk_free)
  );

  // 32 MHz clock for identifier pin 2, only runs while in use
  rate_nco #(
    .MODULUS  (`SYS_CLK_HZ)
  ) u_fast_nco (
    .clk      (pclk),
    .rst_n    (presetn),
    .run      (frac_act),
    .inc      (2 * `FAST_CLK_HZ),
    .clk_q    (fast_clk)
  );

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Counting always runs on the ungapped clock so the gaps never shift framing
  wire        clk_lvl   = cfg_drive_q ? sclk_free : sclk_s;
  wire        bit_ev    = sample_edge(clk_lvl, clk_prev_q, inv_eff);
  wire        ch_ev     = sample_edge(chclk_s, chclk_prev_q, inv_eff);
  // Sync high means the bit now on the wire is bit 0, even before the counter
  // has been realigned; without this the first bit after sync lands in the
  // lane of the stale count
  wire [13:0] pos_cur   = msync_s ? 14'h0000 : pos_q;
  wire [11:0] cpos      = chan_pos(pos_cur, mux_en, speed);
  wire [4:0]  timeslot  = cpos[7:3];
  wire        overhead  = (timeslot == 5'h00);
  wire        mf_first  = (cpos == 12'h000);
  wire [1:0]  chan_sel  = (speed == `SPEED_MUX_BYTE) ? pos_cur[4:3] : pos_cur[1:0];

  // Link bit counter, realigned by the multiframe sync input
  // The count advances on sample edges only, so a stopped link clock
  // freezes the time-slot number on the pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q        <= 14'h0000;
      clk_prev_q   <= 1'b0;
      chclk_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q   <= clk_lvl;
      chclk_prev_q <= chclk_s;
      if (bit_ev)
      begin
        if (msync_s)
          pos_q <= 14'h0001;
        else if (!mux_en && pos_q == 14'h0FFF)
          pos_q <= 14'h0000;
        else
          pos_q <= pos_q + 14'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data capture toward the line side
  // ----------------------------------------------------------------
  // Lane 0 only outside multiplexed mode; the reserved speed code drops
  // every bit rather than guess at a lane order
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_data_q   <= 4'h0;
      line_strobe_q <= 4'h0;
    end
    else
    begin
      line_strobe_q <= 4'h0;
      if (bit_ev && !mux_en)
      begin
        line_data_q[0]   <= data_s;
        line_strobe_q[0] <= 1'b1;
      end
      else if (bit_ev && !mux_resv)
      begin
        line_data_q[chan_sel]   <= data_s;
        line_strobe_q[chan_sel] <= 1'b1;
      end
    end
  end

  // Signaling and fractional inputs on the identifier pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sig_bit_q     <= 1'b0;
      sig_strobe_q  <= 1'b0;
      frac_bit_q    <= 1'b0;
      frac_strobe_q <= 1'b0;
    end
    else
    begin
      sig_strobe_q  <= 1'b0;
      frac_strobe_q <= 1'b0;
      if (bit_ev && (frac_act || !base_rate))
      begin
        sig_bit_q    <= sig_s;
        sig_strobe_q <= 1'b1;
      end
      if (frac_act && !frac_src && ch_ev)
      begin
        frac_bit_q    <= fracd_s;
        frac_strobe_q <= 1'b1;
      end
      else if (frac_act && frac_src && bit_ev && chclk_s)
      begin
        frac_bit_q    <= fracd_s;
        frac_strobe_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Identifier pin functions per mode
  // Pin 0 in fractional or non-base modes, and pin 1 in fractional mode, turn into inputs by dropping their enables; the value
  // under a low enable is kept at zero so nothing toggles there
  always @*
  begin
    ts_o_d  = timeslot;
    ts_oe_d = 5'h1F;
    if (frac_act)
    begin
      ts_oe_d = 5'h1C;
      ts_o_d  = {timeslot[4], mf_first, fast_clk, 2'b00};
    end
    else if (!base_rate)
    begin
      ts_oe_d = 5'h1E;
      ts_o_d  = {timeslot[4:1], 1'b0};
    end
  end

  // Registered outputs; gapping masks the clock during overhead bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeslot_id_pins_o  <= 5'h00;
      timeslot_id_pins_oe <= 5'h00;
      tx_serial_clock_o   <= 1'b0;
      tx_serial_clock_oe  <= 1'b0;
    end
    else
    begin
      timeslot_id_pins_o  <= ts_o_d;
      timeslot_id_pins_oe <= ts_oe_d;
      tx_serial_clock_oe  <= cfg_drive_q;
      tx_serial_clock_o   <= sclk_free & ~(payload_clk & overhead);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state so read data come from a flip-flop
  // ----------------------------------------------------------------
  always @*
  begin
    addr_ok = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr)
      `OFS_CTRL:   rdata_d = {24'h000000, ctrl_q & `CTRL_WMASK};
      `OFS_CFG:    rdata_d = {31'h00000000, cfg_drive_q};
      `OFS_STATUS: rdata_d = {23'h000000, base_rate, mux_resv,
                              frac_bit_q, sig_bit_q, timeslot};
      default:     addr_ok = 1'b0;
    endcase
  end

  // A write takes effect only at the edge where pready is seen high; read data are captured one edge earlier
  // Holding the write until then keeps the mode from changing halfway
  // through a transfer that the master has not yet seen complete
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q      <= `CTRL_RESET;
      cfg_drive_q <= `CFG_RESET;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel && penable && !pready)
        prdata <= pwrite ? 32'h00000000 : rdata_d;
      if (psel && penable && pready && pwrite && !pslverr)
      begin
        if (paddr == `OFS_CTRL)
          ctrl_q <= pwdata[7:0] & `CTRL_WMASK;
        if (paddr == `OFS_CFG)
          cfg_drive_q <= pwdata[`CFG_SCLK_DRIVE];
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/backplane_model.sv
`timescale 1ns/1ns
`default_nettype none

// Backplane source: gated link clock, data launched on the chosen edge
module backplane_model (
  input  wire logic        run,
  input  wire logic        inv,
  input  wire logic [31:0] pattern,
  output var  logic        sclk,
  output var  logic        sdata,
  output var  logic        msync,
  output wire logic [4:0]  pins
);
  int n = 0;

  initial
  begin
    sclk  = 1'h0;
    sdata = 1'h0;
    msync = 1'h0;
  end

  // Clock stands low between bursts; idle data keeps moving so stale bits show
  always #80
  begin
    if (!run)
    begin
      sclk  = 1'h0;
      sdata = ~sdata;
      msync = 1'h0;
      n     = 0;
    end
    else
    begin
      sclk = ~sclk;
      if (sclk ^ inv)
      begin
        sdata <= #20 pattern[n % 32]; // Hold time past the launch edge
        msync <= #20 (n % 32 == 0);
        n = n + 1;
      end
    end
  end

  // Signaling and fractional inputs carry the same stream
  assign pins = {3'h0, sdata, sdata};
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pattern = 32'h0;
  logic        pready, pslverr, err, sclk_o, sclk_oe, m_sclk, sdata, msync, sig_bit_q, sig_strobe_q;
  logic        frac_bit_q, frac_strobe_q, run = 1'h0, inv = 1'h0, mon = 1'h0, mux_chk = 1'h0;
  logic [4:0]  ts_o, ts_oe, m_pins;
  logic [3:0]  line_data_q, line_strobe_q, exp_ch = 4'h0;
  wire  logic  sclk_w = sclk_oe ? sclk_o : m_sclk;
  wire  logic [4:0] ts_w = (ts_oe & ts_o) | (~ts_oe & m_pins);
  int          n_mismatch = 0, n_tests = 0, n_strobe = 0, n_frac = 0, cyc = 0, cnt = 0;

  always #5 pclk = ~pclk;

  tx_backplane_if tx_backplane_if_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_serial_clock_i(sclk_w), .tx_serial_clock_o(sclk_o), .tx_serial_clock_oe(sclk_oe),
    .channel_clock_pin(m_sclk), .tx_serial_data(sdata), .tx_mframe_sync(msync),
    .timeslot_id_pins_i(ts_w), .timeslot_id_pins_o(ts_o), .timeslot_id_pins_oe(ts_oe),
    .line_data_q, .line_strobe_q, .sig_bit_q, .sig_strobe_q, .frac_bit_q, .frac_strobe_q
  );

  backplane_model backplane_model_inst (
    .run, .inv, .pattern, .sclk(m_sclk), .sdata, .msync, .pins(m_pins)
  );

  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait for the answer however long it takes; the hang guard ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One framed burst of 64 link bits with the monitor armed
  task automatic link_run(input logic [7:0] c, input logic [31:0] p, input logic [3:0] e, input int lo, input int hi);
    xfer(1'h1, 12'h000, {24'h0, c});
    pattern  = p;
    exp_ch   = e;
    inv      = c[3] & ~c[2] & (c[1:0] == 2'h0);
    mux_chk  = c[2];
    n_strobe = 0;
    n_frac   = 0;
    repeat (20) @(posedge pclk);
    mon <= 1'h1;
    run = 1'h1;
    repeat (1024) @(posedge pclk);
    run = 1'h0;
    repeat (20) @(posedge pclk);
    mon <= 1'h0;
    check_range(n_strobe, lo, hi);
    $display("Test link control %h done", c);
  endtask

  // Counts rising edges of a generated clock over a window
  task automatic count_rises(input int sel, input int ncyc);
    logic prev = 1'h0;
    logic now;
    cnt = 0;
    repeat (ncyc)
    begin
      @(posedge pclk);
      now = (sel == 0) ? sclk_o : ts_o[2];
      cnt = cnt + ((now === 1'h1 && prev === 1'h0) ? 1 : 0);
      prev = now;
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Strobed bits against the lane map or the bit currently on the wire
  always @(posedge pclk)
  begin
    if (mon)
    begin
      for (int i = 0; i < 4; i++)
        if (line_strobe_q[i] === 1'h1)
        begin
          n_strobe++;
          check_val({31'h0, line_data_q[i]}, {31'h0, mux_chk ? exp_ch[i] : sdata});
        end
      if (sig_strobe_q === 1'h1)
        check_val({31'h0, sig_bit_q}, {31'h0, sdata});
      if (frac_strobe_q === 1'h1)
      begin
        n_frac++;
        check_val({31'h0, frac_bit_q}, {31'h0, sdata});
      end
    end
  end

  // Hang guard, well above the expected run of about 35000 cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    xfer(1'h0, 12'h000, 32'h0);
    check_val(rd, 32'h0);
    xfer(1'h0, 12'h004, 32'h0);
    check_val(rd, 32'h0);
    xfer(1'h1, 12'h000, 32'hFF);
    xfer(1'h0, 12'h000, 32'h0);
    check_val(rd, 32'hBF);
    xfer(1'h1, 12'h00C, 32'hFF);
    check_val({31'h0, err}, 32'h1);
    $display("Test registers done");
    link_run(8'h00, 32'h5A3C96E1, 4'h0, 63, 65);
    check_val({27'h0, ts_o}, 32'h4);
    link_run(8'h08, 32'h5A3C96E1, 4'h0, 63, 65);
    link_run(8'h0D, 32'hCCCCCCCC, 4'hC, 63, 65);
    link_run(8'h06, 32'hFF00FF00, 4'hA, 63, 65);
    link_run(8'h04, 32'hCCCCCCCC, 4'h0, 0, 0);
    link_run(8'h10, 32'h5A3C96E1, 4'h0, 63, 65);
    check_range(n_frac, 63, 65);
    link_run(8'h90, 32'h5A3C96E1, 4'h0, 63, 65);
    check_range(n_frac, 0, 0);
    count_rises(1, 1250);
    check_range(cnt, 398, 402);
    xfer(1'h1, 12'h004, 32'h1);
    xfer(1'h1, 12'h000, 32'h0);
    count_rises(0, 12500);
    check_range(cnt, 254, 258);
    xfer(1'h1, 12'h000, 32'h20);
    count_rises(0, 12500);
    check_range(cnt, 246, 250);
    xfer(1'h1, 12'h000, 32'h5);
    count_rises(0, 1250);
    check_range(cnt, 203, 206);
    $display("Test generated clocks done");
    complete_run();
  end
endmodule

bind tx_backplane_if tx_bp_properties tx_bp_properties_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .tx_serial_clock_oe, .timeslot_id_pins_oe, .line_strobe_q
);

`default_nettype wire

// ===== tb/tx_bp_properties.sv
`timescale 1ns/1ns
`default_nettype none

// Shadows the control word from bus writes; checks pin enables and strobes
module tx_bp_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_serial_clock_oe,
  input wire logic [4:0]  timeslot_id_pins_oe,
  input wire logic [3:0]  line_strobe_q
);
  logic [7:0] ctrl_q;
  logic       cfg_q;
  logic [1:0] settle_q;
  logic       wr_done;
  logic       base;

  // Bus write completion and base-rate decode
  assign wr_done = psel & penable & pready & pwrite;
  assign base    = ~ctrl_q[2] & (ctrl_q[1:0] == 2'h0);

  // Settle count hides the pipeline delay between a write and the pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= 8'h00;
      cfg_q    <= 1'h0;
      settle_q <= 2'h0;
    end
    else
    begin
      settle_q <= wr_done ? 2'h0 : (settle_q == 2'h3 ? 2'h3 : settle_q + 2'h1);
      if (wr_done && paddr == 12'h000)
        ctrl_q <= pwdata[7:0] & 8'hBF;
      if (wr_done && paddr == 12'h004)
        cfg_q <= pwdata[0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  oe_base_a: assert property (
    settle_q == 2'h3 && base && !ctrl_q[4] |-> timeslot_id_pins_oe == 5'h1F) else $error("base pin enables wrong");
  oe_frac_a: assert property (
    settle_q == 2'h3 && base && ctrl_q[4] |-> timeslot_id_pins_oe == 5'h1C) else $error("frac pin enables wrong");
  oe_fast_a: assert property (
    settle_q == 2'h3 && !base |-> timeslot_id_pins_oe == 5'h1E) else $error("fast pin enables wrong");
  sclk_drive_a: assert property (
    settle_q == 2'h3 |-> tx_serial_clock_oe == cfg_q) else $error("serial clock enable wrong");
  ctrl_read_a: assert property (
    pready && psel && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, ctrl_q}) else $error("control readback wrong");
  ready_wait_a: assert property (
    psel && !penable ##1 psel && penable |-> !pready ##1 pready) else $error("ready timing wrong");
  slverr_map_a: assert property (
    psel && pready |-> pslverr == (paddr > 12'h008)) else $error("slave error wrong");
  mux_reserved_a: assert property (
    settle_q == 2'h3 && ctrl_q[2] && ctrl_q[1:0] == 2'h0 |-> line_strobe_q == 4'h0) else $error("reserved code strobes");
  nonmux_lane_a: assert property (
    settle_q == 2'h3 && !ctrl_q[2] |-> line_strobe_q[3:1] == 3'h0) else $error("lane strobe out of mux");
endmodule

`default_nettype wire
